// ### core/wfmc_top.sv
// Purpose: wake frame match configuration registers and frame matcher
// Assumes: register port and received-frame inputs share ref_clk
// Notes: read data appears one cycle after reg_rd; match one cycle
//        after rx_valid
`default_nettype none
// Overview of operation
// - mask bits: ident 12..5 at 15..8, 4..0 at 6..2
// - set mask bit compares, clear ignores
// - mask bit 7 and 1:0 read zero
// - length code in bits 3:0, rest zero
// - codes 8 to 15 mean eight bytes
// - length code must match bit for bit
// - offset 0x37 holds bytes 7 and 6
// - offset 0x38 holds bytes 5 and 4
// - offset 0x39 holds bytes 3 and 2
// - reset and soft reset clear everything
// - restart keeps mask bits, reserved zero
// - restart keeps length code, upper zero
// - restart keeps all payload data bits
// - high mask covers identifier bits 28..13
// - extension bit selects 11 or 29 bits
module wfmc_top
  import wfmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic [28:0] rx_ident,
  input wire logic rx_ide,
  input wire logic [3:0] rx_dlc,
  input wire logic [47:0] rx_payload,
  input wire logic [28:0] cfg_ident,
  input wire logic cfg_ide,
  input wire logic [15:0] cfg_mask_high,
  output logic match_done,
  output logic wake_match
);

  // stored fields hold writable bits only; reserved bits never exist
  logic [12:0] mask_low_q, mask_low_d;
  logic [3:0] dlc_q, dlc_d;
  logic [15:0] bytes_7_6_q, bytes_7_6_d;
  logic [15:0] bytes_5_4_q, bytes_5_4_d;
  logic [15:0] bytes_3_2_q, bytes_3_2_d;
  logic [15:0] rdata_q, rdata_d;
  logic done_q, done_d;
  logic match_q, match_d;

  logic [15:0] mask_low_view;
  logic [15:0] dlc_view;
  logic [28:0] full_mask;
  logic id_ok;
  logic data_ok;
  logic dlc_ok;

  // register view with reserved bits forced to zero
  always_comb begin
    mask_low_view = WFMC_REG_RESET;
    mask_low_view[WFMC_MASK_UPPER_MSB:WFMC_MASK_UPPER_LSB] =
      mask_low_q[WFMC_LOW_MASK_W-1:WFMC_MASK_SPLIT];
    mask_low_view[WFMC_MASK_LOWER_MSB:WFMC_MASK_LOWER_LSB] =
      mask_low_q[WFMC_MASK_SPLIT-1:0];
    mask_low_view[WFMC_MASK_RESV_BIT] = 1'b0;
    dlc_view = WFMC_REG_RESET;
    dlc_view[WFMC_DLC_MSB:0] = dlc_q;
  end

  // register writes
  always_comb begin
    mask_low_d = mask_low_q;
    dlc_d = dlc_q;
    bytes_7_6_d = bytes_7_6_q;
    bytes_5_4_d = bytes_5_4_q;
    bytes_3_2_d = bytes_3_2_q;
    if (soft_reset) begin
      mask_low_d = '0;
      dlc_d = '0;
      bytes_7_6_d = WFMC_REG_RESET;
      bytes_5_4_d = WFMC_REG_RESET;
      bytes_3_2_d = WFMC_REG_RESET;
    end else if (restart) begin
      // restart leaves every writable bit as it was
      mask_low_d = mask_low_q;
      dlc_d = dlc_q;
      bytes_7_6_d = bytes_7_6_q;
      bytes_5_4_d = bytes_5_4_q;
      bytes_3_2_d = bytes_3_2_q;
    end else if (reg_wr) begin
      case (reg_addr)
        WFMC_ADDR_MASK_LOW: begin
          // bits 7 and 1:0 of the write data are dropped
          mask_low_d = {
            reg_wdata[WFMC_MASK_UPPER_MSB:WFMC_MASK_UPPER_LSB],
            reg_wdata[WFMC_MASK_LOWER_MSB:WFMC_MASK_LOWER_LSB]};
        end
        WFMC_ADDR_LENGTH: begin
          dlc_d = reg_wdata[WFMC_DLC_MSB:0];
        end
        WFMC_ADDR_BYTES_7_6: begin
          bytes_7_6_d = reg_wdata;
        end
        WFMC_ADDR_BYTES_5_4: begin
          bytes_5_4_d = reg_wdata;
        end
        WFMC_ADDR_BYTES_3_2: begin
          bytes_3_2_d = reg_wdata;
        end
        default: begin
          mask_low_d = mask_low_q;
        end
      endcase
    end
  end

  // register reads, unmapped addresses return zero
  always_comb begin
    rdata_d = rdata_q;
    if (soft_reset) begin
      rdata_d = WFMC_REG_RESET;
    end else if (reg_rd) begin
      case (reg_addr)
        WFMC_ADDR_MASK_LOW: begin
          rdata_d = mask_low_view;
        end
        WFMC_ADDR_LENGTH: begin
          rdata_d = dlc_view;
        end
        WFMC_ADDR_BYTES_7_6: begin
          rdata_d = bytes_7_6_q;
        end
        WFMC_ADDR_BYTES_5_4: begin
          rdata_d = bytes_5_4_q;
        end
        WFMC_ADDR_BYTES_3_2: begin
          rdata_d = bytes_3_2_q;
        end
        default: begin
          rdata_d = WFMC_READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      mask_low_q <= '0;
      dlc_q <= '0;
      bytes_7_6_q <= WFMC_REG_RESET;
      bytes_5_4_q <= WFMC_REG_RESET;
      bytes_3_2_q <= WFMC_REG_RESET;
      rdata_q <= WFMC_REG_RESET;
    end else begin
      mask_low_q <= mask_low_d;
      dlc_q <= dlc_d;
      bytes_7_6_q <= bytes_7_6_d;
      bytes_5_4_q <= bytes_5_4_d;
      bytes_3_2_q <= bytes_3_2_d;
      rdata_q <= rdata_d;
    end
  end

  // identifier mask: neighbour register supplies bits 28..13
  assign full_mask = {cfg_mask_high, mask_low_q};

  wfmc_id_match u_id_match (
    .rx_ident(rx_ident),
    .rx_ide(rx_ide),
    .cfg_ident(cfg_ident),
    .cfg_ide(cfg_ide),
    .cfg_mask(full_mask),
    .id_ok(id_ok)
  );

  wfmc_data_match #(
    .NUM_BYTES(WFMC_PAYLOAD_BYTES)
  ) u_data_match (
    .rx_bytes(rx_payload),
    .cfg_bytes({bytes_7_6_q, bytes_5_4_q, bytes_3_2_q}),
    .cfg_dlc(dlc_q),
    .data_ok(data_ok)
  );

  // exact code equality; same length by another code fails
  assign dlc_ok = (rx_dlc == dlc_q);

  always_comb begin
    done_d = rx_valid && !soft_reset;
    match_d = rx_valid && !soft_reset && id_ok && dlc_ok && data_ok;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      done_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      done_q <= done_d;
      match_q <= match_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign match_done = done_q;
  assign wake_match = match_q;

endmodule
`default_nettype wire

// ### include/wfmc_pkg.sv
// Purpose: constants shared by the wake frame match configuration block
// Assumes: 7-bit register addresses, 16-bit register data
// Notes: offsets are the register port addresses
`default_nettype none
package wfmc_pkg;

  localparam int WFMC_ADDR_W = 7;
  localparam int WFMC_DATA_W = 16;
  localparam int WFMC_ID_W = 29;
  localparam int WFMC_LOW_MASK_W = 13;
  localparam int WFMC_HIGH_MASK_W = 16;
  localparam int WFMC_DLC_W = 4;
  localparam int WFMC_BYTE_W = 8;
  localparam int WFMC_PAYLOAD_BYTES = 6;
  localparam int WFMC_FIRST_BYTE = 2;

  localparam logic [6:0] WFMC_ADDR_MASK_LOW = 7'h35;
  localparam logic [6:0] WFMC_ADDR_LENGTH = 7'h36;
  localparam logic [6:0] WFMC_ADDR_BYTES_7_6 = 7'h37;
  localparam logic [6:0] WFMC_ADDR_BYTES_5_4 = 7'h38;
  localparam logic [6:0] WFMC_ADDR_BYTES_3_2 = 7'h39;

  localparam logic [15:0] WFMC_REG_RESET = 16'h0000;
  localparam logic [15:0] WFMC_READ_UNMAPPED = 16'h0000;

  // low mask register field positions
  localparam int WFMC_MASK_UPPER_MSB = 15;
  localparam int WFMC_MASK_UPPER_LSB = 8;
  localparam int WFMC_MASK_LOWER_MSB = 6;
  localparam int WFMC_MASK_LOWER_LSB = 2;
  localparam int WFMC_MASK_RESV_BIT = 7;
  localparam int WFMC_MASK_SPLIT = 5;
  localparam int WFMC_DLC_MSB = 3;

  localparam logic [3:0] WFMC_MAX_LEN = 4'h8;
  localparam logic [28:0] WFMC_STD_ID_FIELD = 29'h000007FF;

  // payload length in bytes for a length code
  function automatic logic [3:0] wfmc_payload_len(input logic [3:0] code);
    logic [3:0] len;
    len = code;
    if (code[WFMC_DLC_MSB]) begin
      len = WFMC_MAX_LEN;
    end
    return len;
  endfunction

endpackage
`default_nettype wire

// ### core/wfmc_id_match.sv
// Purpose: masked identifier compare for wake-up frames
// Assumes: standard identifiers sit in identifier bits 10..0
// Notes: purely combinational
`default_nettype none
module wfmc_id_match
  import wfmc_pkg::*;
(
  input wire logic [28:0] rx_ident,
  input wire logic rx_ide,
  input wire logic [28:0] cfg_ident,
  input wire logic cfg_ide,
  input wire logic [28:0] cfg_mask,
  output logic id_ok
);

  logic [28:0] mask_eff;

  always_comb begin
    // mask bits follow the configured identifier length
    mask_eff = cfg_ide ? cfg_mask : (cfg_mask & WFMC_STD_ID_FIELD);
    // set bit compares, clear bit ignores
    id_ok = (rx_ide == cfg_ide) &&
            (((rx_ident ^ cfg_ident) & mask_eff) == '0);
  end

endmodule
`default_nettype wire

// ### core/wfmc_data_match.sv
// Purpose: expected payload byte compare for bytes 7..2
// Assumes: byte n sits at bits 8*(n-2)+7 .. 8*(n-2) of the payload ports
// Notes: bytes at or beyond the payload length are not compared
`default_nettype none
module wfmc_data_match
  import wfmc_pkg::*;
#(
  parameter int NUM_BYTES = WFMC_PAYLOAD_BYTES
) (
  input wire logic [NUM_BYTES*8-1:0] rx_bytes,
  input wire logic [NUM_BYTES*8-1:0] cfg_bytes,
  input wire logic [3:0] cfg_dlc,
  output logic data_ok
);

  logic [3:0] len;

  always_comb begin
    len = wfmc_payload_len(cfg_dlc);
    data_ok = 1'b1;
    for (int i = 0; i < NUM_BYTES; i++) begin
      if (4'(i + WFMC_FIRST_BYTE) < len &&
          rx_bytes[i*WFMC_BYTE_W +: WFMC_BYTE_W] !=
          cfg_bytes[i*WFMC_BYTE_W +: WFMC_BYTE_W]) begin
        data_ok = 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

// ### verif/wfmc_properties.sv
// Purpose: port-level checks of the wake frame match block
// Assumes: one clock domain, async active-low reset
// Notes: bound into wfmc_top
`default_nettype none
module wfmc_checker (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic soft_reset,
  input wire logic [6:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic rx_valid,
  input wire logic rx_ide,
  input wire logic cfg_ide,
  input wire logic match_done,
  input wire logic wake_match
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  a_done_after_frame: assert property (
    rx_valid && !soft_reset |=> match_done)
    else $error("no done after frame");
  a_no_stray_done: assert property (
    !(rx_valid && !soft_reset) |=> !match_done)
    else $error("done without frame");
  a_match_with_done: assert property (
    wake_match |-> match_done)
    else $error("match without done");
  a_ext_bit_differs: assert property (
    rx_valid && rx_ide != cfg_ide |=> !wake_match)
    else $error("match with other ident length");
  a_mask_resv_zero: assert property (
    reg_rd && !soft_reset && reg_addr == 7'h35
    |=> reg_rdata[7] == 1'b0 && reg_rdata[1:0] == 2'h0)
    else $error("reserved mask bits set");
  a_len_upper_zero: assert property (
    reg_rd && !soft_reset && reg_addr == 7'h36
    |=> reg_rdata[15:4] == 12'h000)
    else $error("length upper bits set");
  a_soft_clears: assert property (
    soft_reset |=> reg_rdata == 16'h0000 && !match_done)
    else $error("soft reset left state");
  a_rdata_holds: assert property (
    !reg_rd && !soft_reset |=> $stable(reg_rdata))
    else $error("read data moved");
  cover property (wake_match);
  cover property (match_done && !wake_match);
  cover property (soft_reset);
endmodule
bind wfmc_top wfmc_checker chk (.*);
`default_nettype wire

// ### verif/wfmc_host.sv
// Purpose: controller model driving the register port
// Assumes: one-cycle strobes on ref_clk
// Notes: write data is inverted once released
`default_nettype none
module wfmc_host (
  input wire logic ref_clk,
  output logic [6:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 7'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// ### verif/wfmc_tb_top.sv
// Purpose: register and frame match tests
// Assumes: host model drives the register port
// Notes: payload 7..2 written as A1 B2 C3 D4 E5 F6
`default_nettype none
module wfmc_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, resetn, soft_reset, restart, reg_wr, reg_rd, rx_valid;
  logic rx_ide, cfg_ide, match_done, wake_match;
  logic [6:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd, cfg_mask_high;
  logic [28:0] rx_ident, cfg_ident;
  logic [3:0] rx_dlc;
  logic [47:0] rx_payload;
  logic [47:0] pl = 48'hA1B2C3D4E5F6;
  logic [15:0] ex [6] = '{16'hFF7C, 16'h000F, 16'hFFFF, 16'hFFFF,
    16'hFFFF, 16'h0000};
  int err_count = 0;
  int comparisons = 0;
  wfmc_top dut (.*);
  wfmc_host host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk16(input logic [15:0] g, input logic [15:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %0t flag %b expected %b", $time, g, e);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    host.rd(a, rd);
    chk16(rd, e);
  endtask
  task automatic frame(input logic [3:0] d, input logic [47:0] p,
    input logic e);
    @(posedge ref_clk);
    rx_valid <= 1'b1;
    rx_dlc <= d;
    rx_payload <= p;
    @(posedge ref_clk);
    rx_valid <= 1'b0;
    rx_payload <= ~p;
    #1 chkb(match_done, 1'b1);
    chkb(wake_match, e);
  endtask
  initial begin
    #40000;
    err_count++;
    report_and_stop;
  end
  initial begin
    resetn = 1'b0;
    {soft_reset, restart, rx_valid, rx_ide, cfg_ide} = 5'h00;
    rx_ident = 29'h00000123;
    cfg_ident = 29'h00000123;
    rx_dlc = 4'h0;
    rx_payload = 48'h000000000000;
    cfg_mask_high = 16'h0000;
    repeat (4) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) rdchk(7'(i + 'h35), 16'h0000);
    for (int i = 0; i < 6; i++) host.wr(7'(i + 'h35), 16'hFFFF);
    for (int i = 0; i < 6; i++) begin
      rdchk(7'(i + 'h35), ex[i]);
    end
    @(posedge ref_clk);
    restart <= 1'b1;
    @(posedge ref_clk);
    restart <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rdchk(7'(i + 'h35), ex[i]);
    end
    host.wr(7'h37, 16'hA1B2);
    host.wr(7'h38, 16'hC3D4);
    host.wr(7'h39, 16'hE5F6);
    for (int c = 0; c < 16; c++) begin
      host.wr(7'h36, 16'(c));
      frame(4'(c), pl, 1'b1);
      frame(4'(c) ^ 4'h8, pl, 1'b0);
      frame(4'(c) ^ 4'h1, pl, 1'b0);
      frame(4'(c), pl ^ 48'h010000000000, c < 8);
      frame(4'(c), pl ^ 48'h000000000001, c < 3);
    end
    @(posedge ref_clk);
    rx_ident <= 29'h00000122;
    frame(4'hF, pl, 1'b0);
    host.wr(7'h35, 16'hFF78);
    frame(4'hF, pl, 1'b1);
    @(posedge ref_clk);
    rx_ide <= 1'b1;
    frame(4'hF, pl, 1'b0);
    @(posedge ref_clk);
    soft_reset <= 1'b1;
    @(posedge ref_clk);
    soft_reset <= 1'b0;
    rdchk(7'h37, 16'h0000);
    // power-on style reset in mid-run must clear a written register
    host.wr(7'h38, 16'h5A5A);
    rdchk(7'h38, 16'h5A5A);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rdchk(7'h38, 16'h0000);
    report_and_stop;
  end
endmodule
`default_nettype wire
